// *** hw/tpcs_params.svh ***
// Purpose: constants of the touch panel conversion sequencer
// Assumes: 20 MHz clock, APB with 32-bit data
// Notes: offsets are byte addresses of aligned words
`ifndef TPCS_PARAMS_SVH
`define TPCS_PARAMS_SVH

`define TPCS_OFF_CTRL 8'h00
`define TPCS_OFF_DELAY 8'h04
`define TPCS_OFF_STAT 8'h08
`define TPCS_OFF_MASK 8'h0c
`define TPCS_OFF_RES_Y 8'h10
`define TPCS_OFF_RES_X 8'h14
`define TPCS_OFF_RES_PA 8'h18
`define TPCS_OFF_RES_PB 8'h1c
`define TPCS_OFF_RES_AUX 8'h20

// control word fields
`define TPCS_CTRL_MODE_LSB 0
`define TPCS_CTRL_CHAN_LSB 2
`define TPCS_CTRL_GO_BIT 5
`define TPCS_CTRL_DRV_BIT 6
`define TPCS_CTRL_RES_LSB 8
`define TPCS_CTRL_RST 16'h0000

// delay word fields: stabilise, precharge, sense, in delay units
`define TPCS_DLY_STAB_LSB 0
`define TPCS_DLY_PRE_LSB 8
`define TPCS_DLY_SNS_LSB 16
`define TPCS_DLY_RST 24'h040404

// status and mask bits
`define TPCS_ST_DONE 0
`define TPCS_ST_TOUCH 1

// timing
`define TPCS_CLK_NS 50
`define TPCS_DLY_UNIT_NS 800
`define TPCS_DLY_UNIT_CYC ((`TPCS_DLY_UNIT_NS + `TPCS_CLK_NS - 1) / `TPCS_CLK_NS)

`endif

// *** hw/tpcs_pkg.sv ***
// Purpose: types of the touch panel conversion sequencer
// Assumes: constants live in tpcs_params.svh
// Notes: none
package tpcs_pkg;
  typedef enum logic [1:0] {
    TPCS_MODE_TOUCH = 2'b00,
    TPCS_MODE_PEN = 2'b01,
    TPCS_MODE_HOST = 2'b10,
    TPCS_MODE_HOST2 = 2'b11
  } tpcs_mode_e;

  typedef enum logic [2:0] {
    TPCS_CH_Y = 3'b000,
    TPCS_CH_X = 3'b001,
    TPCS_CH_PA = 3'b010,
    TPCS_CH_PB = 3'b011,
    TPCS_CH_AUX = 3'b100
  } tpcs_chan_e;

  typedef enum logic [2:0] {
    TPCS_SQ_MON = 3'b000,
    TPCS_SQ_CONV = 3'b001,
    TPCS_SQ_PRE = 3'b010,
    TPCS_SQ_SNS = 3'b011,
    TPCS_SQ_DRV = 3'b100
  } tpcs_seq_e;

  typedef enum logic [1:0] {
    TPCS_CV_IDLE = 2'b00,
    TPCS_CV_WAIT = 2'b01,
    TPCS_CV_RUN = 2'b10
  } tpcs_cv_e;
endpackage

// *** hw/tpcs_conv_if.sv ***
// Purpose: request and answer between sequencer and conversion unit
// Assumes: one clock domain
// Notes: req and done are one-cycle pulses
`timescale 1ns/1ps
interface tpcs_conv_if #(parameter int DW = 12);
  logic req;
  logic abort;
  logic [7:0] dly;
  logic done;
  logic [DW-1:0] data;
  modport seq (output req, output abort, output dly, input done,
               input data);
  modport conv (input req, input abort, input dly, output done,
                output data);
endinterface

// *** hw/tpcs_conv.sv ***
// Purpose: settling wait then one converter start and result capture
// Assumes: adc_done pulses once per adc_start
// Notes: dly of zero starts the converter two cycles after req
`timescale 1ns/1ps
`include "tpcs_params.svh"
module tpcs_conv #(
  parameter int DW = 12,
  parameter int UNIT = `TPCS_DLY_UNIT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // sequencer side
  tpcs_conv_if.conv cv,
  // converter core
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [DW-1:0] adc_data
);
  if (UNIT < 1 || UNIT > 255) begin : g_unit_chk
    $error("tpcs_conv: UNIT out of range");
  end

  tpcs_pkg::tpcs_cv_e state_q;
  logic [15:0] cnt_q;
  logic [15:0] tgt_q;
  logic [15:0] wait_len_q;
  logic [DW-1:0] data_q;
  logic done_q;
  logic start_q;
  wire [15:0] wait_cycles = 16'(cv.dly) * 16'(UNIT);

  assign cv.done = done_q;
  assign cv.data = data_q;
  assign adc_start = start_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= tpcs_pkg::TPCS_CV_IDLE;
      cnt_q <= 16'h0000;
      tgt_q <= 16'h0000;
      data_q <= '0;
      done_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      start_q <= 1'b0;
      if (cv.abort) begin
        state_q <= tpcs_pkg::TPCS_CV_IDLE;
      end else begin
        case (state_q)
          tpcs_pkg::TPCS_CV_IDLE: begin
            if (cv.req) begin
              cnt_q <= wait_cycles;
              tgt_q <= wait_cycles;
              state_q <= tpcs_pkg::TPCS_CV_WAIT;
            end
          end
          // panel settles with drivers on before sampling
          tpcs_pkg::TPCS_CV_WAIT: begin
            if (cnt_q == 16'h0000) begin
              start_q <= 1'b1;
              state_q <= tpcs_pkg::TPCS_CV_RUN;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          tpcs_pkg::TPCS_CV_RUN: begin
            if (adc_done) begin
              data_q <= adc_data;
              done_q <= 1'b1;
              state_q <= tpcs_pkg::TPCS_CV_IDLE;
            end
          end
          default: state_q <= tpcs_pkg::TPCS_CV_IDLE;
        endcase
      end
    end
  end

  // helper: cycles spent waiting
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_len_q <= 16'h0000;
    end else if (state_q == tpcs_pkg::TPCS_CV_WAIT) begin
      wait_len_q <= wait_len_q + 16'h0001;
    end else begin
      wait_len_q <= 16'h0000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_settle_time: assert property (
    (state_q == tpcs_pkg::TPCS_CV_WAIT && cnt_q == 16'h0000 && !cv.abort)
    |=> (start_q && wait_len_q == tgt_q + 16'h0001))
    else $error("converter started before settling time elapsed");
endmodule

// *** hw/tpcs_top.sv ***
// Purpose: four-wire resistive panel sequencer with APB registers
// Assumes: touch_sense is low while the pen pulls the X+ line down
// Notes: APB answers in the cycle after setup, no wait states
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "tpcs_params.svh"
module tpcs_top #(
  parameter int DW = 12
) (
  // clock and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic panel_reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // panel drivers and sense
  input wire logic touch_sense,
  output logic xp_to_supply,
  output logic xm_to_ground,
  output logic yp_to_supply,
  output logic ym_to_ground,
  output logic pen_pullup_en,
  output logic precharge_en,
  output logic [2:0] mux_sel,
  // converter core
  output logic adc_start,
  output logic [1:0] adc_res,
  input wire logic adc_done,
  input wire logic [DW-1:0] adc_data,
  // status outputs
  output logic result_ready_n,
  output logic touch_irq_n,
  output logic irq
);
  if (DW < 8 || DW > 16) begin : g_dw_chk
    $error("tpcs_top: DW must be 8 to 16");
  end

  tpcs_conv_if #(.DW(DW)) cvi ();

  tpcs_conv #(.DW(DW)) u_conv (
    .clock(clock),
    .rst_n(rst_n),
    .cv(cvi.conv),
    .adc_start(adc_start),
    .adc_done(adc_done),
    .adc_data(adc_data)
  );

  // panel switch pattern per channel
  function automatic logic [5:0] drive_of(input tpcs_pkg::tpcs_chan_e ch);
    case (ch)
      // {xp, xm, yp, ym, mux}: mux 0 senses X+, 1 Y+, 2 Y-, 3 aux
      tpcs_pkg::TPCS_CH_Y: drive_of = {4'b0011, 2'd0};
      tpcs_pkg::TPCS_CH_X: drive_of = {4'b1100, 2'd1};
      tpcs_pkg::TPCS_CH_PA: drive_of = {4'b0110, 2'd0};
      tpcs_pkg::TPCS_CH_PB: drive_of = {4'b0110, 2'd2};
      default: drive_of = {4'b0000, 2'd3};
    endcase
  endfunction

  // registers
  logic [15:0] ctrl_q;
  logic [23:0] dly_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [15:0] res_q [5];
  logic [4:0] new_q;
  tpcs_pkg::tpcs_seq_e seq_q;
  logic [2:0] chan_q;
  logic [1:0] idx_q;
  logic [11:0] tcnt_q;
  logic touched_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [5:0] drv_q;
  logic pen_q;
  logic pre_q;
  logic req_q;
  logic irqn_q;
  logic irq_q;
  logic rdy_n_q;

  // bus decode
  wire setup = psel && !penable;
  wire acc = psel && penable && pready_q;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = paddr == `TPCS_OFF_CTRL;
  wire hit_dly = paddr == `TPCS_OFF_DELAY;
  wire hit_stat = paddr == `TPCS_OFF_STAT;
  wire hit_mask = paddr == `TPCS_OFF_MASK;
  wire [7:0] res_off = paddr - `TPCS_OFF_RES_Y;
  wire hit_res = paddr >= `TPCS_OFF_RES_Y && paddr <= `TPCS_OFF_RES_AUX &&
                 paddr[1:0] == 2'b00;
  wire [2:0] res_idx = res_off[4:2];
  wire mapped = hit_ctrl || hit_dly || hit_stat || hit_mask || hit_res;
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_q} :
                       hit_dly ? {8'h00, dly_q} :
                       hit_stat ? {30'h0, stat_q} :
                       hit_mask ? {30'h0, mask_q} :
                       hit_res ? {16'h0000, res_q[res_idx]} : 32'h0;

  // host command fields; go is a write-only strobe
  wire go = wr && hit_ctrl && pwdata[`TPCS_CTRL_GO_BIT];
  wire drv_only = pwdata[`TPCS_CTRL_DRV_BIT];
  wire [2:0] cmd_chan = pwdata[`TPCS_CTRL_CHAN_LSB +: 3];
  wire [1:0] mode = ctrl_q[`TPCS_CTRL_MODE_LSB +: 2];
  wire [1:0] cmd_mode = pwdata[`TPCS_CTRL_MODE_LSB +: 2];
  wire host_mode = cmd_mode[1];
  wire [7:0] stab = dly_q[`TPCS_DLY_STAB_LSB +: 8];
  wire [11:0] pre_cyc = 12'(dly_q[`TPCS_DLY_PRE_LSB +: 8]) *
                        12'(`TPCS_DLY_UNIT_CYC);
  wire [11:0] sns_cyc = 12'(dly_q[`TPCS_DLY_SNS_LSB +: 8]) *
                        12'(`TPCS_DLY_UNIT_CYC);
  wire pen_down = !touch_sense;
  wire touch_evt = seq_q == tpcs_pkg::TPCS_SQ_MON && pen_down && !touched_q;
  wire auto_start = mode == tpcs_pkg::TPCS_MODE_TOUCH && touch_evt;
  wire pen_start = go && cmd_mode == tpcs_pkg::TPCS_MODE_PEN;
  wire host_go = go && host_mode && seq_q != tpcs_pkg::TPCS_SQ_CONV;
  wire last_pos = idx_q == 2'd3;
  wire [4:0] done_bit = cvi.done ? 5'(5'b00001 << chan_q) : 5'b00000;
  wire [4:0] rd_clr = (rd && hit_res) ? 5'(5'b00001 << res_idx) : 5'b00000;

  assign cvi.req = req_q;
  assign cvi.abort = panel_reset;
  assign cvi.dly = mode[1] ? 8'h00 : stab;

  // apb slave: capture in setup, answer in access
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0 : rd_mux;
        pslverr_q <= !mapped;
      end
    end
  end

  // software registers; hardware set wins over write-one clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `TPCS_CTRL_RST;
      dly_q <= `TPCS_DLY_RST;
      stat_q <= 2'b00;
      mask_q <= 2'b00;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_q <= pwdata[15:0] & 16'hff9f;
      end
      if (wr && hit_dly) begin
        dly_q <= pwdata[23:0];
      end
      if (wr && hit_mask) begin
        mask_q <= pwdata[1:0];
      end
      stat_q <= (stat_q & ~((wr && hit_stat) ? pwdata[1:0] : 2'b00)) |
                {touch_evt, cvi.done};
    end
  end

  // results and data-available tracking
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++) begin
        res_q[i] <= 16'h0000;
      end
      new_q <= 5'b00000;
    end else if (panel_reset) begin
      new_q <= 5'b00000;
    end else begin
      if (cvi.done) begin
        res_q[chan_q] <= 16'(cvi.data);
      end
      new_q <= (new_q & ~rd_clr) | done_bit;
    end
  end

  // sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= tpcs_pkg::TPCS_SQ_MON;
      chan_q <= 3'd0;
      idx_q <= 2'd0;
      tcnt_q <= 12'h000;
      req_q <= 1'b0;
      touched_q <= 1'b0;
    end else if (panel_reset) begin
      seq_q <= tpcs_pkg::TPCS_SQ_MON;
      req_q <= 1'b0;
      touched_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      if (seq_q == tpcs_pkg::TPCS_SQ_MON) begin
        touched_q <= pen_down;
      end
      case (seq_q)
        tpcs_pkg::TPCS_SQ_MON, tpcs_pkg::TPCS_SQ_DRV: begin
          if (host_go && drv_only) begin
            chan_q <= cmd_chan;
            seq_q <= tpcs_pkg::TPCS_SQ_DRV;
          end else if (host_go) begin
            chan_q <= cmd_chan;
            req_q <= 1'b1;
            seq_q <= tpcs_pkg::TPCS_SQ_CONV;
          end else if (auto_start || pen_start) begin
            chan_q <= 3'(tpcs_pkg::TPCS_CH_Y);
            idx_q <= 2'd0;
            req_q <= 1'b1;
            seq_q <= tpcs_pkg::TPCS_SQ_CONV;
          end
        end
        tpcs_pkg::TPCS_SQ_CONV: begin
          if (cvi.done && mode[1]) begin
            seq_q <= tpcs_pkg::TPCS_SQ_MON;
          end else if (cvi.done && !last_pos) begin
            idx_q <= idx_q + 2'd1;
            chan_q <= {1'b0, idx_q + 2'd1};
            req_q <= 1'b1;
          end else if (cvi.done) begin
            tcnt_q <= pre_cyc;
            seq_q <= tpcs_pkg::TPCS_SQ_PRE;
          end
        end
        tpcs_pkg::TPCS_SQ_PRE: begin
          if (tcnt_q == 12'h000) begin
            tcnt_q <= sns_cyc;
            seq_q <= tpcs_pkg::TPCS_SQ_SNS;
          end else begin
            tcnt_q <= tcnt_q - 12'h001;
          end
        end
        tpcs_pkg::TPCS_SQ_SNS: begin
          if (tcnt_q != 12'h000) begin
            tcnt_q <= tcnt_q - 12'h001;
          end else if (pen_down && mode == tpcs_pkg::TPCS_MODE_TOUCH) begin
            chan_q <= 3'(tpcs_pkg::TPCS_CH_Y);
            idx_q <= 2'd0;
            req_q <= 1'b1;
            seq_q <= tpcs_pkg::TPCS_SQ_CONV;
          end else begin
            touched_q <= pen_down; // no new edge while still held
            seq_q <= tpcs_pkg::TPCS_SQ_MON;
          end
        end
        default: seq_q <= tpcs_pkg::TPCS_SQ_MON;
      endcase
    end
  end

  // panel switch and status outputs, all registered
  wire conv_like = seq_q == tpcs_pkg::TPCS_SQ_CONV ||
                   seq_q == tpcs_pkg::TPCS_SQ_DRV;
  wire [5:0] drv_d = conv_like ? drive_of(tpcs_pkg::tpcs_chan_e'(chan_q)) :
                     6'b000011;
  wire mon = seq_q == tpcs_pkg::TPCS_SQ_MON;
  wire sensing = mon || seq_q == tpcs_pkg::TPCS_SQ_SNS;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drv_q <= 6'b000000;
      pen_q <= 1'b0;
      pre_q <= 1'b0;
      irqn_q <= 1'b1;
      irq_q <= 1'b0;
      rdy_n_q <= 1'b1;
    end else if (panel_reset) begin
      drv_q <= 6'b000000;
      pen_q <= 1'b0;
      pre_q <= 1'b0;
      irqn_q <= 1'b1;
      irq_q <= 1'b0;
      rdy_n_q <= 1'b1;
    end else begin
      // only Y- is on while monitoring or precharging is off
      drv_q <= seq_q == tpcs_pkg::TPCS_SQ_PRE ? 6'b000000 :
               sensing ? 6'b000100 : drv_d;
      pen_q <= sensing;
      pre_q <= seq_q == tpcs_pkg::TPCS_SQ_PRE;
      irqn_q <= !(mon && pen_down);
      irq_q <= |(stat_q & mask_q);
      rdy_n_q <= ~|((new_q & ~rd_clr) | done_bit);
    end
  end

  assign {xp_to_supply, xm_to_ground, yp_to_supply, ym_to_ground} =
         drv_q[5:2];
  assign mux_sel = {1'b0, drv_q[1:0]};
  assign pen_pullup_en = pen_q;
  assign precharge_en = pre_q;
  assign touch_irq_n = irqn_q;
  assign irq = irq_q;
  assign result_ready_n = rdy_n_q;
  assign adc_res = ctrl_q[`TPCS_CTRL_RES_LSB +: 2];
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_conv_done;
    cvi.done && !panel_reset;
  endsequence

  a_done_ready: assert property (s_conv_done |=> !result_ready_n)
    else $error("data available not shown after conversion");
  a_ready_level: assert property (
    (new_q == 5'b00000 && !cvi.done) |=> result_ready_n)
    else $error("data available low with no unread data");
  a_pen_decouple: assert property (
    (seq_q == tpcs_pkg::TPCS_SQ_CONV) |=> !pen_pullup_en)
    else $error("pen path connected during measurement");
  a_pen_irq: assert property (
    (mon && pen_down && !panel_reset) |=> !touch_irq_n)
    else $error("touch not reported");
  a_reset_pin: assert property (panel_reset |=>
    (seq_q == tpcs_pkg::TPCS_SQ_MON && drv_q == 6'b000000 &&
    new_q == 5'b00000))
    else $error("reset pin did not return to idle");
  // a fresh host command right after the result is a legal restart
  a_host_single: assert property ((s_conv_done ##0 mode[1]) |=>
    (!req_q ##1 (!req_q || $past(go))))
    else $error("host mode started an unrequested conversion");
  a_precharge_off: assert property (precharge_en |->
    (!xm_to_ground && !yp_to_supply && !ym_to_ground))
    else $error("drivers on during precharge");
  a_y_drive: assert property (
    (seq_q == tpcs_pkg::TPCS_SQ_CONV && chan_q == 3'd0 && !panel_reset)
    |=> (yp_to_supply && ym_to_ground && !xp_to_supply && mux_sel == 3'd0))
    else $error("wrong panel drive for Y measurement");
  a_seq_order: assert property (
    (s_conv_done ##0 !mode[1] ##0 chan_q == 3'd0) |=> chan_q == 3'd1)
    else $error("X did not follow Y");
  // the reset pin forces irq low while status bits keep their values
  a_irq_level: assert property (
    (((stat_q & mask_q) != 2'b00) && !panel_reset) |=> irq)
    else $error("masked interrupt not raised");
endmodule

// *** testbench/tpcs_adc_model.sv ***
// Purpose: converter core stand-in that answers start pulses
// Assumes: one start at a time, fixed conversion time
// Notes: data lines toggle outside the done cycle so stale data shows
`timescale 1ns/1ps
module tpcs_adc_model #(
  parameter int LAT = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // converter handshake
  input wire logic adc_start,
  output logic adc_done,
  output logic [11:0] adc_data,
  output logic [11:0] last_data
);
  int cnt_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 0;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
      last_data <= 12'h5a0;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start) begin
        cnt_q <= LAT;
      end else if (cnt_q == 1) begin
        cnt_q <= 0;
        adc_done <= 1'b1;
        adc_data <= last_data + 12'h011;
        last_data <= last_data + 12'h011;
      end else if (cnt_q > 1) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule

// *** testbench/touch_panel_conversion_sequencer_tb_top.sv ***
// Purpose: register-level bench of the panel sequencer
// Assumes: APB answers in the cycle after setup; bench still waits for pready
// Notes: resolution code for coarse pressure reads is arbitrary here
`timescale 1ns/1ps
`include "tpcs_params.svh"
module touch_panel_conversion_sequencer_tb_top;
  localparam logic [1:0] RES_LOW = 2'h1;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic panel_reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic touch_sense = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq, adc_start, adc_done;
  logic xp_to_supply, xm_to_ground, yp_to_supply, ym_to_ground;
  logic pen_pullup_en, precharge_en, result_ready_n, touch_irq_n;
  logic [2:0] mux_sel;
  logic [1:0] adc_res;
  logic [11:0] adc_data, last_data;
  int error_cnt = 0;
  int num_checks = 0;
  int starts = 0;
  int waited;
  logic [3:0] exp_drv [4] = '{4'b0011, 4'b1100, 4'b0110, 4'b0110};
  logic [2:0] exp_mux [5] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h3};
  wire [3:0] drv = {xp_to_supply, xm_to_ground, yp_to_supply, ym_to_ground};

  always #25 clock = ~clock;

  always @(posedge clock) begin
    if (adc_start === 1'b1) starts <= starts + 1;
  end

  tpcs_top #(.DW(12)) i_tpcs_top (
    .clock(clock), .rst_n(rst_n), .panel_reset(panel_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .touch_sense(touch_sense),
    .xp_to_supply(xp_to_supply), .xm_to_ground(xm_to_ground),
    .yp_to_supply(yp_to_supply), .ym_to_ground(ym_to_ground),
    .pen_pullup_en(pen_pullup_en), .precharge_en(precharge_en),
    .mux_sel(mux_sel), .adc_start(adc_start), .adc_res(adc_res),
    .adc_done(adc_done), .adc_data(adc_data),
    .result_ready_n(result_ready_n), .touch_irq_n(touch_irq_n), .irq(irq));

  tpcs_adc_model i_tpcs_adc_model (
    .clock(clock), .rst_n(rst_n), .adc_start(adc_start),
    .adc_done(adc_done), .adc_data(adc_data), .last_data(last_data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // no latency assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // 0 start, 1 precharge, 2 pen down, 3 data available
  task automatic wait_for(input int sel);
    logic hit;
    waited = 0;
    do begin
      @(posedge clock);
      waited++;
      case (sel)
        0: hit = adc_start;
        1: hit = precharge_en;
        2: hit = !touch_irq_n;
        default: hit = !result_ready_n;
      endcase
    end while (hit !== 1'b1);
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    int s0, n1;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk({drv[0], pen_pullup_en, result_ready_n, touch_irq_n}, 4'hf);
    chk({drv[3:1], irq}, 4'h0);
    apb(0, `TPCS_OFF_CTRL, 0);
    chk(rd, 32'h0);
    apb(0, `TPCS_OFF_DELAY, 0);
    chk(rd, {8'h00, `TPCS_DLY_RST});
    apb(0, 8'h40, 0);
    chk(err, 1);
    chk(rd, 0);
    apb(1, `TPCS_OFF_MASK, 32'h1);
    for (int ch = 0; ch < 5; ch++) begin
      s0 = starts;
      apb(1, `TPCS_OFF_CTRL, 32'h22 | (ch << 2));
      wait_for(0);
      chk(mux_sel, exp_mux[ch]);
      if (ch < 4) chk(drv, exp_drv[ch]);
      if (ch < 2) chk(pen_pullup_en, 0);
      wait_for(3);
      apb(0, 8'h10 + 8'(ch * 4), 0);
      chk(rd, {20'h0, last_data});
      repeat (40) @(posedge clock);
      chk(result_ready_n, 1);
      chk(starts - s0, 1);
    end
    chk(irq, 1);
    apb(1, `TPCS_OFF_STAT, 32'h1);
    repeat (3) @(posedge clock);
    chk(irq, 0);
    apb(1, `TPCS_OFF_MASK, 32'h0);
    // drivers only, then a separate convert after the host's settle time
    s0 = starts;
    apb(1, `TPCS_OFF_CTRL, 32'h66);
    repeat (10) @(posedge clock);
    chk(drv, 4'b1100);
    chk(starts - s0, 0);
    apb(1, `TPCS_OFF_CTRL, 32'h26);
    wait_for(0);
    chk(drv, 4'b1100);
    wait_for(3);
    apb(0, `TPCS_OFF_RES_X, 0);
    chk(rd, {20'h0, last_data});
    // host-started sequence, two settle settings two units apart
    for (int k = 0; k < 2; k++) begin
      apb(1, `TPCS_OFF_DELAY, 32'h040401 + 32'(k * 2));
      apb(1, `TPCS_OFF_CTRL, 32'h21 | (RES_LOW << 8));
      wait_for(0);
      if (k == 0) n1 = waited;
      else chk(waited - n1, 2 * `TPCS_DLY_UNIT_CYC);
      chk(mux_sel, 0);
      for (int i = 1; i < 4; i++) begin
        wait_for(0);
        chk(mux_sel, exp_mux[i]);
      end
      chk(adc_res, RES_LOW);
      wait_for(1);
      chk(drv, 0);
      repeat (200) @(posedge clock);
    end
    chk(result_ready_n, 0);
    chk(irq, 0);
    panel_reset <= 1'b1;
    repeat (2) @(posedge clock);
    chk({drv, pen_pullup_en, result_ready_n, touch_irq_n}, 7'h03);
    panel_reset <= 1'b0;
    repeat (2) @(posedge clock);
    chk({ym_to_ground, pen_pullup_en, result_ready_n}, 3'h7);
    // touch-started mode
    apb(1, `TPCS_OFF_MASK, 32'h2);
    apb(1, `TPCS_OFF_CTRL, 32'h0);
    touch_sense <= 1'b0;
    wait_for(2);
    wait_for(0);
    chk(mux_sel, 0);
    touch_sense <= 1'b1;
    wait_for(1);
    repeat (200) @(posedge clock);
    chk(irq, 1);
    chk(touch_irq_n, 1);
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    tally_and_finish;
  end
endmodule
